// ---- bcu_params.svh ----
`ifndef BCU_PARAMS_SVH
`define BCU_PARAMS_SVH

// Register offsets
`define BCU_OFF_PF_LIM_HI 8'h2C
`define BCU_OFF_IO_HI     8'h30
`define BCU_OFF_CAP       8'h34
`define BCU_OFF_ROM       8'h38
`define BCU_OFF_INTR      8'h3C

// Reset and fixed values
`define BCU_RST32         32'h0000_0000
`define BCU_RST16         16'h0000
`define BCU_RST8          8'h00
`define BCU_RST6          6'h00
`define BCU_ONES32        32'hFFFF_FFFF
`define BCU_ROM_VALUE     32'h0000_0000
`define BCU_CAP_NORMAL    8'h80
`define BCU_CAP_LEGACY    8'h90
`define BCU_PIN_CODE      8'h01

// Field positions
`define BCU_IOB_MSB       15
`define BCU_IOB_LSB       0
`define BCU_IOL_MSB       31
`define BCU_IOL_LSB       16
`define BCU_LINE_MSB      7
`define BCU_LINE_LSB      0
`define BCU_PIN_MSB       15
`define BCU_PIN_LSB       8
`define BCU_BC_MSB        21
`define BCU_BC_LSB        16
`define BCU_BC_PERR       16
`define BCU_BC_SERR       17
`define BCU_BC_ISA        18
`define BCU_BC_VGA        19
`define BCU_BC_VGA16      20
`define BCU_BC_MABORT     21

// Legacy decode constants
`define BCU_ISA_TOP_LSB   16
`define BCU_ALIAS_MSB     9
`define BCU_ALIAS_LSB     8
`define BCU_IO_LO_FILL    12'h000
`define BCU_IO_HI_FILL    12'hFFF
`define BCU_VGA_MEM_LSB   17
`define BCU_VGA_MEM_TAG   15'h0005
`define BCU_VGA_IO_A_LO   10'h3B0
`define BCU_VGA_IO_A_HI   10'h3BB
`define BCU_VGA_IO_B_LO   10'h3C0
`define BCU_VGA_IO_B_HI   10'h3DF

`endif

// ---- bcu_pkg.sv ----
`default_nettype none
package bcu_pkg;
  // Outcome of an unclaimed secondary-side access
  typedef enum logic [1:0] {
    BCU_MA_NONE  = 2'h0,
    BCU_MA_QUIET = 2'h1,
    BCU_MA_TA    = 2'h3,
    BCU_MA_SERR  = 2'h2
  } bcu_ma_t;
endpackage : bcu_pkg
`default_nettype wire

// ---- bcu_fwd_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bcu_params.svh"
module bcu_fwd_decode #(
  parameter int AW = 32
) (
  // Window setup
  input  wire logic [15:0]   io_base_hi,
  input  wire logic [15:0]   io_limit_hi,
  input  wire logic [3:0]    io_base_lo,
  input  wire logic [3:0]    io_limit_lo,
  input  wire logic          io_enable,
  input  wire logic          mem_enable,
  input  wire logic          isa_mode,
  input  wire logic          vga_en,
  input  wire logic          vga_16bit,
  // Request
  input  wire logic          req_is_io,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic          req_mem_hit,
  // Decision
  output logic               fwd_down,
  output logic               alias_up
);
  logic [31:0] io_base;
  logic [31:0] io_limit;
  logic        io_win;
  logic        vga_io;
  logic        vga_mem;
  logic        vga_hit;

  function automatic logic in_vga_io(input logic [9:0] a);
    in_vga_io = (a >= `BCU_VGA_IO_A_LO && a <= `BCU_VGA_IO_A_HI) ||
                (a >= `BCU_VGA_IO_B_LO && a <= `BCU_VGA_IO_B_HI);
  endfunction : in_vga_io

  assign io_base  = {io_base_hi, io_base_lo, `BCU_IO_LO_FILL};
  assign io_limit = {io_limit_hi, io_limit_lo, `BCU_IO_HI_FILL};
  assign io_win = req_is_io && io_enable && (req_addr >= io_base) && (req_addr <= io_limit);
  // ISA alias goes upstream, display hit wins
  assign alias_up = isa_mode && io_win && !vga_hit &&
                    (req_addr[AW-1:`BCU_ISA_TOP_LSB] == '0) &&
                    (req_addr[`BCU_ALIAS_MSB:`BCU_ALIAS_LSB] != 2'h0);
  // 10 or 16 bit display decode
  assign vga_io = in_vga_io(req_addr[9:0]) &&
                  (!vga_16bit || (req_addr[AW-1:10] == '0));
  assign vga_mem = (req_addr[AW-1:`BCU_VGA_MEM_LSB] == `BCU_VGA_MEM_TAG);
  assign vga_hit = vga_en && (req_is_io ? (io_enable && vga_io)
                                        : (mem_enable && vga_mem));
  assign fwd_down = vga_hit ||
                    (req_is_io ? (io_win && !alias_up) : req_mem_hit);
endmodule : bcu_fwd_decode
`default_nettype wire

// ---- bcu_cfg_upper.sv ----
// Operation
// - RW prefetch limit upper word, reset zero
// - RW I/O base upper half, reset zero
// - RW I/O limit upper half, reset zero
// - Capability pointer 80h, legacy mode 90h
// - Expansion ROM word always reads zero
// - RW interrupt line byte, not interpreted
// - Interrupt pin reads fixed 01h
// - Bit 16 gates secondary parity error response
// - Bit 17 gates SERR forwarding upstream
// - ISA clear: forward whole I/O window down
// - ISA set: alias I/O addresses go upstream
// - Display enable forwards legacy display ranges
// - Bit 20 selects 10/16-bit display decode
// - Abort mode clear: ones on read, drop write
// - Abort mode set: target abort else SERR if bit 17 set
`timescale 1ns/1ps
`default_nettype none
`include "bcu_params.svh"
module bcu_cfg_upper #(
  parameter int AW = 32
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  // Register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata_q,
  // Mode pin and lower header
  input  wire logic          legacy_mode_pin,
  input  wire logic [3:0]    io_base_lo,
  input  wire logic [3:0]    io_limit_lo,
  input  wire logic          io_enable,
  input  wire logic          mem_enable,
  // Forwarding decision
  input  wire logic          req_valid,
  input  wire logic          req_is_io,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic          req_mem_hit,
  output logic               fwd_valid_q,
  output logic               fwd_down_q,
  output logic               fwd_alias_up_q,
  // Secondary errors
  input  wire logic          sec_perr,
  input  wire logic          sec_serr,
  output logic               perr_report_q,
  output logic               err_msg_q,
  // Master abort handling
  input  wire logic          ma_event,
  input  wire logic          ma_is_read,
  input  wire logic          ma_ta_ok,
  output logic               ma_quiet_q,
  output logic      [31:0]   ma_rdata_q,
  output logic               ma_target_abort_q,
  output logic               ma_serr_q,
  // Register contents
  output logic      [31:0]   pf_limit_hi_q,
  output logic      [15:0]   io_base_hi_q,
  output logic      [15:0]   io_limit_hi_q,
  output logic      [7:0]    intr_line_q,
  output logic      [5:0]    bridge_ctl_q
);
  logic          legacy_s1_q;
  logic          legacy_q;
  logic          wr_pf;
  logic          wr_io;
  logic          wr_intr;
  logic [31:0]   rdata_d;
  logic          fwd_down;
  logic          alias_up;
  logic          ctl_perr;
  logic          ctl_serr;
  logic          ctl_ma;
  bcu_pkg::bcu_ma_t ma_kind;

  //////////////////////////////////////////////////////////////////////////////
  // Mode pin synchroniser
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      legacy_s1_q <= 1'b0;
      legacy_q    <= 1'b0;
    end else begin
      legacy_s1_q <= legacy_mode_pin;
      legacy_q    <= legacy_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_pf   = reg_wr && (reg_addr == `BCU_OFF_PF_LIM_HI);
  assign wr_io   = reg_wr && (reg_addr == `BCU_OFF_IO_HI);
  assign wr_intr = reg_wr && (reg_addr == `BCU_OFF_INTR);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pf_limit_hi_q <= `BCU_RST32;
    end else if (wr_pf) begin
      pf_limit_hi_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io_base_hi_q <= `BCU_RST16;
    end else if (wr_io) begin
      io_base_hi_q <= reg_wdata[`BCU_IOB_MSB:`BCU_IOB_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io_limit_hi_q <= `BCU_RST16;
    end else if (wr_io) begin
      io_limit_hi_q <= reg_wdata[`BCU_IOL_MSB:`BCU_IOL_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      intr_line_q <= `BCU_RST8;
    end else if (wr_intr) begin
      intr_line_q <= reg_wdata[`BCU_LINE_MSB:`BCU_LINE_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bridge_ctl_q <= `BCU_RST6;
    end else if (wr_intr) begin
      bridge_ctl_q <= reg_wdata[`BCU_BC_MSB:`BCU_BC_LSB];
    end
  end

  assign ctl_perr = bridge_ctl_q[`BCU_BC_PERR - `BCU_BC_LSB];
  assign ctl_serr = bridge_ctl_q[`BCU_BC_SERR - `BCU_BC_LSB];
  assign ctl_ma   = bridge_ctl_q[`BCU_BC_MABORT - `BCU_BC_LSB];

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    rdata_d = `BCU_RST32;
    unique case (reg_addr)
      `BCU_OFF_PF_LIM_HI: rdata_d = pf_limit_hi_q;
      `BCU_OFF_IO_HI:     rdata_d = {io_limit_hi_q, io_base_hi_q};
      `BCU_OFF_CAP: rdata_d[7:0] = legacy_q ? `BCU_CAP_LEGACY : `BCU_CAP_NORMAL;
      `BCU_OFF_ROM:       rdata_d = `BCU_ROM_VALUE;
      `BCU_OFF_INTR: begin
        rdata_d[`BCU_LINE_MSB:`BCU_LINE_LSB] = intr_line_q;
        rdata_d[`BCU_PIN_MSB:`BCU_PIN_LSB]   = `BCU_PIN_CODE;
        rdata_d[`BCU_BC_MSB:`BCU_BC_LSB]     = bridge_ctl_q;
      end
      default:            rdata_d = `BCU_RST32;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= `BCU_RST32;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= `BCU_RST32;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address forwarding
  bcu_fwd_decode #(
    .AW (AW)
  ) u_decode (
    .io_base_hi  (io_base_hi_q),
    .io_limit_hi (io_limit_hi_q),
    .io_base_lo  (io_base_lo),
    .io_limit_lo (io_limit_lo),
    .io_enable   (io_enable),
    .mem_enable  (mem_enable),
    .isa_mode    (bridge_ctl_q[`BCU_BC_ISA - `BCU_BC_LSB]),
    .vga_en      (bridge_ctl_q[`BCU_BC_VGA - `BCU_BC_LSB]),
    .vga_16bit   (bridge_ctl_q[`BCU_BC_VGA16 - `BCU_BC_LSB]),
    .req_is_io   (req_is_io),
    .req_addr    (req_addr),
    .req_mem_hit (req_mem_hit),
    .fwd_down    (fwd_down),
    .alias_up    (alias_up)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fwd_valid_q    <= 1'b0;
      fwd_down_q     <= 1'b0;
      fwd_alias_up_q <= 1'b0;
    end else begin
      fwd_valid_q    <= req_valid;
      fwd_down_q     <= req_valid && fwd_down;
      fwd_alias_up_q <= req_valid && alias_up;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Secondary error gating
  // Parity errors ignored when clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      perr_report_q <= 1'b0;
    end else begin
      perr_report_q <= sec_perr && ctl_perr;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      err_msg_q <= 1'b0;
    end else begin
      err_msg_q <= sec_serr && ctl_serr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master abort handling
  always_comb begin
    if (!ma_event) begin
      ma_kind = bcu_pkg::BCU_MA_NONE;
    end else if (!ctl_ma) begin
      ma_kind = bcu_pkg::BCU_MA_QUIET;
    end else if (ma_ta_ok) begin
      ma_kind = bcu_pkg::BCU_MA_TA;
    end else begin
      ma_kind = bcu_pkg::BCU_MA_SERR;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ma_quiet_q        <= 1'b0;
      ma_rdata_q        <= `BCU_RST32;
      ma_target_abort_q <= 1'b0;
      ma_serr_q         <= 1'b0;
    end else begin
      ma_quiet_q <= (ma_kind == bcu_pkg::BCU_MA_QUIET);
      ma_rdata_q <= ((ma_kind == bcu_pkg::BCU_MA_QUIET) && ma_is_read) ?
                    `BCU_ONES32 : `BCU_RST32;
      // Target abort, else SERR if enabled
      ma_target_abort_q <= (ma_kind == bcu_pkg::BCU_MA_TA);
      ma_serr_q         <= (ma_kind == bcu_pkg::BCU_MA_SERR) && ctl_serr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_cap_wr;
    reg_wr && (reg_addr == `BCU_OFF_CAP);
  endsequence

  sequence s_cap_rd;
    reg_rd && (reg_addr == `BCU_OFF_CAP) && !reg_wr;
  endsequence

  sequence s_line_wr;
    wr_intr;
  endsequence

  sequence s_line_rd;
    reg_rd && (reg_addr == `BCU_OFF_INTR) && !reg_wr;
  endsequence

  pf_limit_write_a : assert property (
    wr_pf |=> pf_limit_hi_q == $past(reg_wdata))
    else $error("prefetch limit upper word not written");

  io_base_write_a : assert property (
    wr_io |=> io_base_hi_q == $past(reg_wdata[15:0]))
    else $error("io base upper half not written");

  io_limit_write_a : assert property (
    wr_io |=> io_limit_hi_q == $past(reg_wdata[31:16]))
    else $error("io limit upper half not written");

  cap_pointer_a : assert property (
    s_cap_rd |=> reg_rdata_q == {24'h000000,
      ($past(legacy_q) ? `BCU_CAP_LEGACY : `BCU_CAP_NORMAL)})
    else $error("capability pointer value wrong");

  rom_zero_a : assert property (
    reg_rd && (reg_addr == `BCU_OFF_ROM) |=> reg_rdata_q == `BCU_RST32)
    else $error("expansion rom word not zero");

  line_readback_a : assert property (
    (s_line_wr ##1 s_line_rd) |=>
      reg_rdata_q[7:0] == $past(reg_wdata[7:0], 2))
    else $error("interrupt line not read back");

  pin_code_a : assert property (
    s_line_rd |=> reg_rdata_q[15:8] == `BCU_PIN_CODE)
    else $error("interrupt pin code wrong");

  perr_gate_a : assert property (
    sec_perr |=> perr_report_q == $past(ctl_perr))
    else $error("parity error gating wrong");

  serr_fwd_a : assert property (
    !ctl_serr |=> !err_msg_q)
    else $error("serr forwarded while disabled");

  alias_split_a : assert property (
    fwd_alias_up_q |-> !fwd_down_q)
    else $error("isa alias forwarded downstream");

  ma_quiet_a : assert property (
    ma_event && ma_is_read && !ctl_ma |=>
      ma_quiet_q && (ma_rdata_q == `BCU_ONES32) && !ma_target_abort_q)
    else $error("quiet master abort wrong");

  ma_report_a : assert property (
    ma_event && ctl_ma |=> !ma_quiet_q &&
      (ma_target_abort_q == $past(ma_ta_ok)) &&
      (ma_serr_q == (!$past(ma_ta_ok) && $past(ctl_serr))))
    else $error("reported master abort wrong");

  cap_readonly_a : assert property (
    (s_cap_wr ##1 s_cap_rd) |=> reg_rdata_q[31:8] == 24'h000000)
    else $error("read-only pointer word changed");

endmodule : bcu_cfg_upper
`default_nettype wire

// ---- bcu_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcu_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Register port
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata_q
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write; idle lines show inverted values, never stale ones
  // Write is followed with no gap by a read of the same word
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clk_sys);
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata_q;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata_q;
  endtask : rd
endmodule : bcu_host_model
`default_nettype wire

// ---- bcu_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, ma_rdata_q, pf_limit_hi_q;
  logic        reg_wr, reg_rd;
  logic        legacy_mode_pin = 1'b0, req_valid = 1'b0, req_is_io = 1'b0;
  logic        req_mem_hit = 1'b0, sec_perr = 1'b0, sec_serr = 1'b0;
  logic        ma_event = 1'b0, ma_is_read = 1'b0, ma_ta_ok = 1'b0;
  logic [31:0] req_addr = 32'h0000_0000;
  logic        io_en = 1'b1, mem_en = 1'b1;
  logic        fwd_valid_q, fwd_down_q, fwd_alias_up_q, perr_report_q, err_msg_q;
  logic        ma_quiet_q, ma_target_abort_q, ma_serr_q;
  logic [15:0] io_base_hi_q, io_limit_hi_q;
  logic [7:0]  intr_line_q;
  logic [5:0]  bridge_ctl_q;
  int          fail_count = 0;
  int          tests_run = 0;
  logic [31:0] lfsr = 32'hE2B0965F;
  // Reference model of the register contents
  logic [31:0] m_pf = 32'h0;
  logic [15:0] m_iob = 16'h0, m_iol = 16'h0;
  logic [7:0]  m_line = 8'h00;
  logic [5:0]  m_ctl = 6'h00;
  logic        m_leg = 1'b0;
  logic [7:0]  addrs [7] = '{8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h00};
  logic [31:0] faddr [10] = '{32'h1100, 32'h1050, 32'h4000, 32'h03C0, 32'h53B5,
                              32'h2FFF, 32'h3000, 32'hA0000, 32'hC0000, 32'h13C5};

  always #2.5 clk_sys = ~clk_sys;

  bcu_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  bcu_cfg_upper #(.AW(32)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .legacy_mode_pin(legacy_mode_pin), .io_base_lo(4'h1),
    .io_limit_lo(4'h2), .io_enable(io_en), .mem_enable(mem_en), .req_valid(req_valid),
    .req_is_io(req_is_io), .req_addr(req_addr), .req_mem_hit(req_mem_hit),
    .fwd_valid_q(fwd_valid_q), .fwd_down_q(fwd_down_q), .fwd_alias_up_q(fwd_alias_up_q),
    .sec_perr(sec_perr), .sec_serr(sec_serr), .perr_report_q(perr_report_q),
    .err_msg_q(err_msg_q), .ma_event(ma_event), .ma_is_read(ma_is_read),
    .ma_ta_ok(ma_ta_ok), .ma_quiet_q(ma_quiet_q), .ma_rdata_q(ma_rdata_q),
    .ma_target_abort_q(ma_target_abort_q), .ma_serr_q(ma_serr_q),
    .pf_limit_hi_q(pf_limit_hi_q), .io_base_hi_q(io_base_hi_q),
    .io_limit_hi_q(io_limit_hi_q), .intr_line_q(intr_line_q), .bridge_ctl_q(bridge_ctl_q));

  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C1_1DB7 : 32'h0);
    return lfsr;
  endfunction : next_rand

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h2C:   return m_pf;
      8'h30:   return {m_iol, m_iob};
      8'h34:   return m_leg ? 32'h90 : 32'h80;
      8'h3C:   return {10'h000, m_ctl, 8'h01, m_line};
      default: return 32'h0;
    endcase
  endfunction : exp_rd

  // Expected {down, alias} from window, display and alias rules
  function automatic logic [1:0] fwd_exp(input logic io, input logic [31:0] a,
                                         input logic hit);
    logic win, vio, vmem, als;
    win  = io && io_en && a >= {m_iob, 4'h1, 12'h000} && a <= {m_iol, 4'h2, 12'hFFF};
    vio  = io && io_en && m_ctl[3] && ((a[9:0] >= 10'h3B0 && a[9:0] <= 10'h3BB) ||
           (a[9:0] >= 10'h3C0 && a[9:0] <= 10'h3DF)) && (!m_ctl[4] || a[31:10] == 22'h0);
    vmem = !io && mem_en && m_ctl[3] && a[31:17] == 15'h0005;
    als  = win && m_ctl[2] && a[31:16] == 16'h0 && a[9:8] != 2'h0 && !vio;
    return {vmem || vio || (io ? (win && !als) : hit), als};
  endfunction : fwd_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic host_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.wr(a, d, q);
    if (a == 8'h2C) m_pf = d;
    if (a == 8'h30) {m_iol, m_iob} = d;
    if (a == 8'h3C) {m_ctl, m_line} = {d[21:16], d[7:0]};
    chk(q, exp_rd(a));
  endtask : host_wr

  task automatic check_all();
    logic [31:0] d;
    foreach (addrs[i]) begin
      host.rd(addrs[i], d);
      chk(d, exp_rd(addrs[i]));
    end
    chk(pf_limit_hi_q, m_pf);
    chk({io_limit_hi_q, io_base_hi_q}, {m_iol, m_iob});
    chk({18'h0, bridge_ctl_q, intr_line_q}, {18'h0, m_ctl, m_line});
  endtask : check_all

  task automatic req(input logic io, input logic [31:0] a, input logic hit);
    @(posedge clk_sys);
    req_valid   <= 1'b1;
    req_is_io   <= io;
    req_addr    <= a;
    req_mem_hit <= hit;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req_addr  <= ~a;
    #1;
    chk({29'h0, fwd_valid_q, fwd_down_q, fwd_alias_up_q},
        {29'h0, 1'b1, fwd_exp(io, a, hit)});
  endtask : req

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [5:0]  c;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check_all();
    repeat (24) begin
      d = next_rand();
      host_wr(addrs[d[7:0] % 7], next_rand());
      check_all();
    end
    // Legacy pin switches the pointer after its synchroniser
    @(posedge clk_sys);
    legacy_mode_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    m_leg = 1'b1;
    check_all();
    @(posedge clk_sys);
    legacy_mode_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    m_leg = 1'b0;
    check_all();
    for (int k = 0; k < 8; k++) begin
      c = {k[2], 3'b000, k[1], k[0]};
      host_wr(8'h3C, {10'h000, c, 16'h0000});
      for (int j = 0; j < 4; j++) begin
        @(posedge clk_sys);
        {sec_perr, sec_serr, ma_event} <= 3'b111;
        {ma_is_read, ma_ta_ok} <= j[1:0];
        @(posedge clk_sys);
        {sec_perr, sec_serr, ma_event} <= 3'b000;
        {ma_is_read, ma_ta_ok} <= ~j[1:0];
        #1;
        chk({31'h0, perr_report_q}, {31'h0, c[0]});
        chk({31'h0, err_msg_q}, {31'h0, c[1]});
        chk({31'h0, ma_quiet_q}, {31'h0, !c[5]});
        chk(ma_rdata_q, (!c[5] && j[1]) ? 32'hFFFF_FFFF : 32'h0);
        chk({30'h0, ma_target_abort_q, ma_serr_q},
            {30'h0, c[5] && j[0], c[5] && !j[0] && c[1]});
      end
    end
    host_wr(8'h30, 32'h0000_0000);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      io_en  <= !k[3] || k[1];
      mem_en <= !k[3] || !k[1];
      host_wr(8'h3C, {10'h000, 1'b0, k[2:0], 2'b00, 16'h0000});
      foreach (faddr[i]) begin
        d = next_rand();
        req(1'b1, faddr[i], d[0]);
        req(1'b0, faddr[i], d[1]);
      end
    end
    stop_test();
  end
endmodule : tb
`default_nettype wire
